// >>> common/sbcd_cfg.svh
/*
 * Timing and encoding constants for the status bus command decoder.
 * Assumes a 200 MHz processor clock (5 ns period).
 */
`ifndef SBCD_CFG_SVH
`define SBCD_CFG_SVH

`define SBCD_CLK_PERIOD_NS  5
`define SBCD_GRANT_DELAY_NS 115
// Least time rounds up to whole cycles
`define SBCD_GRANT_CYCLES   ((`SBCD_GRANT_DELAY_NS + `SBCD_CLK_PERIOD_NS - 1) / `SBCD_CLK_PERIOD_NS)
`define SBCD_GRANT_CNT_W    5
`define SBCD_EARLY_LEAD     1
`define SBCD_EARLY_HOLD     2

`define SBCD_ST_INT_ACK     3'h0
`define SBCD_ST_IORD        3'h1
`define SBCD_ST_IOWR        3'h2
`define SBCD_ST_HALT        3'h3
`define SBCD_ST_FETCH       3'h4
`define SBCD_ST_MRD         3'h5
`define SBCD_ST_MWR         3'h6
`define SBCD_ST_PASSIVE     3'h7

`endif

// >>> common/sbcd_pkg.sv
/*
 * Types for the status bus command decoder.
 * Assumes nothing beyond the configuration header.
 */
package sbcd_pkg;
	typedef logic [2:0] sbcd_status_t;
	typedef enum logic [1:0] {
		SBCD_IDLE,
		SBCD_WAIT,
		SBCD_LEAD,
		SBCD_CMD
	} sbcd_state_e;
endpackage

// >>> testbench/sbcd_cpu_arb_model.sv
/*
 * Processor status and arbiter grant model for the decoder bench.
 * Assumes start pulses arrive only while busy is low.
 */
module sbcd_cpu_arb_model
(
	input  wire logic                   i_clk,
	input  wire logic                   i_start,
	input  wire sbcd_pkg::sbcd_status_t i_code,
	input  wire logic [7:0]             i_hold,
	input  wire logic                   i_bus_free,
	output sbcd_pkg::sbcd_status_t      o_status,
	output logic                        o_grant_n,
	output logic                        o_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	import sbcd_pkg::*;
	logic [7:0] left_reg = 8'h00;
	initial o_status = 3'h7;
	initial o_grant_n = 1'b1;
	always @(posedge i_clk)
		o_grant_n <= ~i_bus_free;
	// Status falls back to passive between cycles
	always @(posedge i_clk)
	begin
		if (i_start)
		begin
			o_status <= i_code;
			left_reg <= i_hold;
		end
		else if (left_reg > 8'h01)
			left_reg <= left_reg - 8'h01;
		else
		begin
			left_reg <= 8'h00;
			o_status <= 3'h7;
		end
	end
	assign o_busy = (left_reg != 8'h00);
endmodule // sbcd_cpu_arb_model

// >>> testbench/sbcd_top_tb.sv
/*
 * Self-checking bench for the status bus command decoder.
 * Assumes commands change only on rising edges; checked at falling edges.
 */
`include "sbcd_cfg.svh"
module sbcd_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sbcd_pkg::*;
	typedef struct {logic [6:0] vec; int gap;} sbcd_exp_s;
	logic clk, rst_b, io_sel, start, bus_free, busy, grant_n;
	logic [7:0] hold_r;
	sbcd_status_t code_r, status;
	wire [6:0] cmd;
	logic [6:0] last;
	logic data_en_n, dir, ale, casc_en;
	sbcd_exp_s exp_q[$];
	sbcd_exp_s e;
	int n_errors = 0;
	int cmp_count = 0;
	int gap_cnt = 0;
	sbcd_cpu_arb_model cpu (.i_clk(clk), .i_start(start), .i_code(code_r), .i_hold(hold_r),
		.i_bus_free(bus_free), .o_status(status), .o_grant_n(grant_n), .o_busy(busy));
	sbcd_top dut (.I_CLK(clk), .I_RST_B(rst_b), .I_CPU_STATUS(status), .I_IO_BUS_SELECT(io_sel),
		.I_ARBITER_GRANT_N(grant_n), .O_INT_ACK_CMD_N(cmd[6]), .O_IO_READ_CMD_N(cmd[5]),
		.O_IO_WRITE_CMD_N(cmd[4]), .O_EARLY_IO_WRITE_CMD_N(cmd[3]), .O_MEM_READ_CMD_N(cmd[2]),
		.O_MEM_WRITE_CMD_N(cmd[1]), .O_EARLY_MEM_WRITE_CMD_N(cmd[0]),
		.O_PERIPH_DATA_ENABLE_N(data_en_n), .O_TRANSFER_DIRECTION(dir),
		.O_ADDR_LATCH_STROBE(ale), .O_CASCADE_ENABLE(casc_en));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ----------------------------------------
	// Compare and report
	// ----------------------------------------
	task automatic cmp_cmd(input logic [6:0] got, input logic [6:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_cmd({6'h00, got}, {6'h00, exp});
	endtask
	task automatic end_sim();
		$display("Counts: %0d compares, %0d errors", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Any unlisted command change is a fault
	always @(negedge clk)
	begin
		gap_cnt++;
		if (!rst_b)
			last = 7'h7f;
		else if (cmd !== last)
		begin
			if (exp_q.size() == 0)
				cmp_cmd(cmd, last);
			else
			begin
				e = exp_q.pop_front();
				cmp_cmd(cmd, e.vec);
				if (e.gap != 0)
					cmp_bit(gap_cnt == e.gap, 1'b1);
			end
			gap_cnt = 0;
			last = cmd;
		end
	end
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	task automatic settle();
		int n;
		n = 0;
		while ((busy || exp_q.size() != 0) && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		if (busy || exp_q.size() != 0)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, exp_q.size(), 0);
			end_sim();
		end
		else
			repeat (3) @(posedge clk);
	endtask
	task automatic run(input sbcd_status_t c, input logic go);
		logic rd;
		rd = (c == `SBCD_ST_INT_ACK || c == `SBCD_ST_IORD || c[2:1] == 2'b10);
		if (go)
		case (c)
			`SBCD_ST_INT_ACK: exp_q.push_back('{7'h3f, 0});
			`SBCD_ST_IORD: exp_q.push_back('{7'h5f, 0});
			`SBCD_ST_IOWR: begin exp_q.push_back('{7'h77, 0}); exp_q.push_back('{7'h67, 1}); end
			`SBCD_ST_MWR: begin exp_q.push_back('{7'h7e, 0}); exp_q.push_back('{7'h7c, 1}); end
			`SBCD_ST_FETCH, `SBCD_ST_MRD: exp_q.push_back('{7'h7b, 0});
			default: go = 1'b0;
		endcase
		if (go)
			exp_q.push_back('{7'h7f, 0});
		@(posedge clk);
		start <= 1'b1;
		code_r <= c;
		hold_r <= 8'h06 + 8'($urandom % 4);
		@(posedge clk);
		start <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		// Strobe pulses at the first edge that sees a bus status
		cmp_bit(ale, c != `SBCD_ST_HALT && c != `SBCD_ST_PASSIVE);
		cmp_bit(casc_en, c == `SBCD_ST_INT_ACK);
		repeat (3) @(posedge clk);
		@(negedge clk);
		// Direction follows status even while the grant is pending
		cmp_bit(dir, !rd);
		cmp_bit(data_en_n, !(io_sel && go && !c[2]));
		cmp_bit(ale || casc_en, 1'b0);
		settle();
	endtask
	initial
	begin
		rst_b = 1'b0;
		io_sel = 1'b1;
		start = 1'b0;
		code_r = 3'h7;
		hold_r = 8'h00;
		bus_free = 1'b0;
		void'($urandom(57));
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		for (int m = 0; m < 4; m++)
		begin
			io_sel <= m[0];
			bus_free <= m[1];
			repeat (30) @(posedge clk);
			for (int c = 0; c < 8; c++)
				run(3'(c), m[1] | (m[0] && c < 3));
			$display("Test mode %0d done", m);
		end
		// Grant falls while a system bus read waits
		io_sel <= 1'b0;
		bus_free <= 1'b0;
		repeat (5) @(posedge clk);
		exp_q.push_back('{7'h5f, 0});
		exp_q.push_back('{7'h7f, 0});
		start <= 1'b1;
		code_r <= `SBCD_ST_IORD;
		hold_r <= 8'd60;
		@(posedge clk);
		start <= 1'b0;
		bus_free <= 1'b1;
		// Last falling edge before 115 ns of grant have passed
		repeat (23) @(posedge clk);
		@(negedge clk);
		cmp_bit(cmd[5], 1'b1);
		settle();
		$display("Test grant delay done");
		end_sim();
	end
endmodule // sbcd_top_tb

// >>> verilog/sbcd_grant_timer.sv
/*
 * Grant qualification timer: counts cycles since the arbiter grant went low.
 * Assumes the grant input is synchronous to the clock.
 */
`include "sbcd_cfg.svh"

module sbcd_grant_timer
(
	input  wire logic i_clk,
	input  wire logic i_rst_b,
	input  wire logic i_grant_n,
	output logic      o_ready
);
	logic [`SBCD_GRANT_CNT_W-1:0] cnt_reg;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b || i_grant_n)
			cnt_reg <= '0;
		else if (cnt_reg != `SBCD_GRANT_CNT_W'(`SBCD_GRANT_CYCLES))
			cnt_reg <= cnt_reg + `SBCD_GRANT_CNT_W'(1);
	end

	assign o_ready = (cnt_reg == `SBCD_GRANT_CNT_W'(`SBCD_GRANT_CYCLES));
endmodule // sbcd_grant_timer

// >>> verilog/sbcd_top.sv
/*
 * Status bus command decoder: turns processor status into active-low
 * memory and I/O commands, with early write strobes and arbiter gating.
 * Assumes status and grant inputs are synchronous to I_CLK.
 */
// Notes on behaviour
// - Commands come only from status; halt and passive give none.
// - 000 interrupt ack, 001 I/O read, 010 I/O write plus early write.
// - 100 and 101 memory read; 110 memory write plus early write.
// - I/O bus mode: I/O commands ignore the arbiter grant.
// - I/O bus mode: I/O command without wait; drive data enable, direction.
// - I/O bus mode: memory commands still wait for grant low.
// - Select low means system bus mode; all commands wait for arbitration.
// - System bus mode: no command until 115 ns after grant low.
// - A dedicated grant input lets several masters share a bus.
// - Early writes fall one cycle before the normal write.
// - Early writes stay low with the normal write until status ends the cycle.
// - Latch strobe and cascade enable rise on later of clock and status.
`include "sbcd_cfg.svh"

module sbcd_top
(
	input  wire logic              I_CLK,
	input  wire logic              I_RST_B,
	input  wire sbcd_pkg::sbcd_status_t I_CPU_STATUS,
	input  wire logic              I_IO_BUS_SELECT,
	input  wire logic              I_ARBITER_GRANT_N,
	output logic                   O_INT_ACK_CMD_N,
	output logic                   O_IO_READ_CMD_N,
	output logic                   O_IO_WRITE_CMD_N,
	output logic                   O_EARLY_IO_WRITE_CMD_N,
	output logic                   O_MEM_READ_CMD_N,
	output logic                   O_MEM_WRITE_CMD_N,
	output logic                   O_EARLY_MEM_WRITE_CMD_N,
	output logic                   O_PERIPH_DATA_ENABLE_N,
	output logic                   O_TRANSFER_DIRECTION,
	output logic                   O_ADDR_LATCH_STROBE,
	output logic                   O_CASCADE_ENABLE
);
	import sbcd_pkg::*;

	//------------------------------------------------------------
	// Decode
	//------------------------------------------------------------
	sbcd_state_e  state_reg;
	sbcd_status_t cyc_reg;
	sbcd_status_t prev_status_reg;
	logic         grant_ok;
	logic         is_io;
	logic         is_active;
	logic         cyc_io;
	logic         cyc_write;
	logic         may_go;

	assign is_active = (I_CPU_STATUS != `SBCD_ST_HALT) &&
		(I_CPU_STATUS != `SBCD_ST_PASSIVE);
	assign is_io     = !I_CPU_STATUS[2];
	assign cyc_io    = !cyc_reg[2];
	assign cyc_write = (cyc_reg == `SBCD_ST_IOWR) || (cyc_reg == `SBCD_ST_MWR);

	sbcd_grant_timer u_grant_timer
	(
		.i_clk     (I_CLK),
		.i_rst_b   (I_RST_B),
		.i_grant_n (I_ARBITER_GRANT_N),
		.o_ready   (grant_ok)
	);

	// I/O cycles bypass the arbiter only when the I/O bus is selected
	assign may_go = (I_IO_BUS_SELECT && cyc_io) || grant_ok;

	//------------------------------------------------------------
	// Cycle sequencer
	//------------------------------------------------------------
	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_B)
		begin
			state_reg <= SBCD_IDLE;
			cyc_reg   <= `SBCD_ST_PASSIVE;
		end
		else if (!is_active)
		begin
			state_reg <= SBCD_IDLE;
			cyc_reg   <= `SBCD_ST_PASSIVE;
		end
		else
		begin
			unique case (state_reg)
				SBCD_IDLE:
				begin
					cyc_reg   <= I_CPU_STATUS;
					state_reg <= SBCD_WAIT;
				end
				SBCD_WAIT:
					if (may_go)
						state_reg <= cyc_write ? SBCD_LEAD : SBCD_CMD;
				SBCD_LEAD:
					state_reg <= SBCD_CMD;
				SBCD_CMD:
					state_reg <= SBCD_CMD;
			endcase
		end
	end

	//------------------------------------------------------------
	// Command outputs
	//------------------------------------------------------------
	logic run;
	logic early;
	assign run   = is_active && ((state_reg == SBCD_CMD) ||
		(state_reg == SBCD_LEAD));
	assign early = is_active && (state_reg == SBCD_WAIT) && may_go && cyc_write;

	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_B)
		begin
			O_INT_ACK_CMD_N         <= 1'h1;
			O_IO_READ_CMD_N         <= 1'h1;
			O_IO_WRITE_CMD_N        <= 1'h1;
			O_EARLY_IO_WRITE_CMD_N  <= 1'h1;
			O_MEM_READ_CMD_N        <= 1'h1;
			O_MEM_WRITE_CMD_N       <= 1'h1;
			O_EARLY_MEM_WRITE_CMD_N <= 1'h1;
		end
		else
		begin
			O_INT_ACK_CMD_N  <= !(run && cyc_reg == `SBCD_ST_INT_ACK);
			O_IO_READ_CMD_N  <= !(run && cyc_reg == `SBCD_ST_IORD);
			O_IO_WRITE_CMD_N <= !(run && state_reg == SBCD_LEAD &&
				cyc_reg == `SBCD_ST_IOWR) &&
				!(run && state_reg == SBCD_CMD && cyc_reg == `SBCD_ST_IOWR &&
				!O_IO_WRITE_CMD_N);
			O_EARLY_IO_WRITE_CMD_N <= !((early || run) &&
				cyc_reg == `SBCD_ST_IOWR);
			O_MEM_READ_CMD_N <= !(run && (cyc_reg == `SBCD_ST_FETCH ||
				cyc_reg == `SBCD_ST_MRD));
			O_MEM_WRITE_CMD_N <= !(run && state_reg == SBCD_LEAD &&
				cyc_reg == `SBCD_ST_MWR) &&
				!(run && state_reg == SBCD_CMD && cyc_reg == `SBCD_ST_MWR &&
				!O_MEM_WRITE_CMD_N);
			O_EARLY_MEM_WRITE_CMD_N <= !((early || run) &&
				cyc_reg == `SBCD_ST_MWR);
		end
	end

	//------------------------------------------------------------
	// Transceiver steering
	//------------------------------------------------------------
	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_B)
		begin
			O_PERIPH_DATA_ENABLE_N <= 1'h1;
			O_TRANSFER_DIRECTION   <= 1'h1;
		end
		else
		begin
			O_PERIPH_DATA_ENABLE_N <= !(is_active && I_IO_BUS_SELECT && is_io &&
				state_reg != SBCD_IDLE);
			// Direction high means transmit; reads turn it around
			O_TRANSFER_DIRECTION <= !(is_active && state_reg != SBCD_IDLE &&
				!cyc_write);
		end
	end

	//------------------------------------------------------------
	// Address latch strobe and cascade enable
	//------------------------------------------------------------
	// Single-edge design: a new status is seen at the clock after it
	// settles, which is the later of the two events.
	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_B)
		begin
			prev_status_reg     <= `SBCD_ST_PASSIVE;
			O_ADDR_LATCH_STROBE <= 1'h0;
			O_CASCADE_ENABLE    <= 1'h0;
		end
		else
		begin
			prev_status_reg     <= I_CPU_STATUS;
			O_ADDR_LATCH_STROBE <= is_active &&
				prev_status_reg == `SBCD_ST_PASSIVE;
			O_CASCADE_ENABLE    <= I_CPU_STATUS == `SBCD_ST_INT_ACK &&
				prev_status_reg == `SBCD_ST_PASSIVE;
		end
	end

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	property p_quiet_passive;
		@(posedge I_CLK) disable iff (!I_RST_B)
		!is_active |=> O_MEM_READ_CMD_N && O_IO_READ_CMD_N && O_INT_ACK_CMD_N &&
			O_MEM_WRITE_CMD_N && O_IO_WRITE_CMD_N;
	endproperty
	a_quiet_passive: assert property (p_quiet_passive)
		else $error("command active on idle status");

	property p_early_leads;
		@(posedge I_CLK) disable iff (!I_RST_B)
		$fell(O_EARLY_MEM_WRITE_CMD_N) && I_CPU_STATUS == `SBCD_ST_MWR
			|=> !O_MEM_WRITE_CMD_N;
	endproperty
	a_early_leads: assert property (p_early_leads)
		else $error("write did not follow early write by one cycle");

	property p_early_hold;
		@(posedge I_CLK) disable iff (!I_RST_B)
		$fell(O_EARLY_IO_WRITE_CMD_N) ##1 is_active |-> !O_EARLY_IO_WRITE_CMD_N;
	endproperty
	a_early_hold: assert property (p_early_hold)
		else $error("early write shorter than two cycles");

	property p_sys_wait;
		@(posedge I_CLK) disable iff (!I_RST_B)
		!I_IO_BUS_SELECT && I_ARBITER_GRANT_N |=> ##1 O_MEM_READ_CMD_N &&
			O_IO_READ_CMD_N && O_INT_ACK_CMD_N;
	endproperty
	a_sys_wait: assert property (p_sys_wait)
		else $error("command issued without grant");

	property p_mem_wait;
		@(posedge I_CLK) disable iff (!I_RST_B)
		I_ARBITER_GRANT_N[*2] |=> O_MEM_READ_CMD_N;
	endproperty
	a_mem_wait: assert property (p_mem_wait)
		else $error("memory read without grant");

	property p_io_free;
		@(posedge I_CLK) disable iff (!I_RST_B)
		I_IO_BUS_SELECT && I_CPU_STATUS == `SBCD_ST_IORD &&
			state_reg == SBCD_WAIT ##1 is_active |=> !O_IO_READ_CMD_N;
	endproperty
	a_io_free: assert property (p_io_free)
		else $error("I/O read waited in I/O bus mode");

	property p_data_enable;
		@(posedge I_CLK) disable iff (!I_RST_B)
		!O_IO_READ_CMD_N && I_IO_BUS_SELECT |-> !O_PERIPH_DATA_ENABLE_N;
	endproperty
	a_data_enable: assert property (p_data_enable)
		else $error("data enable off during I/O command");

	property p_read_dir;
		@(posedge I_CLK) disable iff (!I_RST_B)
		!O_MEM_READ_CMD_N |-> !O_TRANSFER_DIRECTION;
	endproperty
	a_read_dir: assert property (p_read_dir)
		else $error("direction wrong for read");
endmodule // sbcd_top
